// File: src/group_irq_pkg.sv
// Package with register map, field layout and carrier types of the interrupt group enable block.
package group_irq_pkg;
    localparam int GROUP_COUNT = 19;
    localparam int GROUP_LSB = 8;
    localparam int GROUP_MSB = 26;
    localparam int SOURCE_COUNT = 31;
    localparam logic [11:0] GROUP_ENABLE_SET_OFFSET = 12'h200;
    localparam logic [11:0] GROUP_ENABLE_CLEAR_OFFSET = 12'h204;
    localparam logic [11:0] GROUP_INTERRUPT_VECTOR_OFFSET = 12'h208;
    localparam logic [GROUP_COUNT-1:0] GROUP_ENABLE_RESET = 19'h00000;
    localparam logic [GROUP_COUNT-1:0] GROUP_VECTOR_RESET = 19'h00000;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_request_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_answer_type;
endpackage : group_irq_pkg

// File: src/interrupt_group_block_enable.sv
// Block-level enable and vector logic of the interrupt aggregator with a classic Wishbone slave.
//
// Implementation choice: the Wishbone interface to the registers.
module interrupt_group_block_enable (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire group_irq_pkg::wb_request_type wb_req_i,
    output group_irq_pkg::wb_answer_type wb_ans_o,
    // Per-source flags and enables, one word of sources for each group.
    input wire logic [group_irq_pkg::GROUP_COUNT*group_irq_pkg::SOURCE_COUNT-1:0] source_flag_bit_i,
    input wire logic [group_irq_pkg::GROUP_COUNT*group_irq_pkg::SOURCE_COUNT-1:0] source_enable_bit_i,
    // Group interrupt lines to the core interrupt controller.
    output logic [group_irq_pkg::GROUP_COUNT-1:0] group_irq_o
);
    import group_irq_pkg::*;

    logic [GROUP_COUNT-1:0] group_enable_reg;
    logic [GROUP_COUNT-1:0] group_vector_reg;
    logic [GROUP_COUNT-1:0] group_vector_next;
    logic [GROUP_COUNT-1:0] group_any_result;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic access;
    logic wr_set;
    logic wr_clear;
    logic wr_vector;
    logic rd_set;
    logic rd_clear;
    logic rd_vector;
    logic rd_other;
    logic [GROUP_COUNT-1:0] wr_bits;

    // Lane 1..3 carry bits 26:8, so a group bit is written when its byte lane is selected.
    function automatic logic [GROUP_COUNT-1:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return m[GROUP_MSB:GROUP_LSB];
    endfunction : lane_mask

    function automatic logic [31:0] place_groups(input logic [GROUP_COUNT-1:0] g);
        logic [31:0] w;
        w = 32'h00000000;
        w[GROUP_MSB:GROUP_LSB] = g;
        return w;
    endfunction : place_groups

    // One place decides whether a request addresses a given register for the write path and the decoded
    // accesses; the read data path and some checks below compare the address on their own.
    function automatic logic reg_hit(input logic [11:0] adr, input logic [11:0] offset);
        return adr == offset;
    endfunction : reg_hit

    // A request is answered once; ack falls in the cycle after it was given.
    assign access = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
    assign wr_set = access && wb_req_i.we && reg_hit(wb_req_i.adr, GROUP_ENABLE_SET_OFFSET);
    assign wr_clear = access && wb_req_i.we && reg_hit(wb_req_i.adr, GROUP_ENABLE_CLEAR_OFFSET);

    // Decoded accesses used by the checks; writes to the vector word have no effect.
    assign wr_vector = access && wb_req_i.we && reg_hit(wb_req_i.adr, GROUP_INTERRUPT_VECTOR_OFFSET);
    assign rd_set = access && !wb_req_i.we && reg_hit(wb_req_i.adr, GROUP_ENABLE_SET_OFFSET);
    assign rd_clear = access && !wb_req_i.we && reg_hit(wb_req_i.adr, GROUP_ENABLE_CLEAR_OFFSET);
    assign rd_vector = access && !wb_req_i.we && reg_hit(wb_req_i.adr, GROUP_INTERRUPT_VECTOR_OFFSET);
    assign rd_other = access && !wb_req_i.we && !rd_set && !rd_clear && !rd_vector;

    // Group bits that the present write carries, after byte lane gating.
    assign wr_bits = wb_req_i.dat[GROUP_MSB:GROUP_LSB] & lane_mask(wb_req_i.sel);

    genvar gi;
    generate
        for (gi = 0; gi < GROUP_COUNT; gi++) begin : g_group
            logic [SOURCE_COUNT-1:0] result;
            assign result = source_flag_bit_i[gi*SOURCE_COUNT +: SOURCE_COUNT]
                & source_enable_bit_i[gi*SOURCE_COUNT +: SOURCE_COUNT];
            assign group_any_result[gi] = |result;
        end
    endgenerate

    assign group_vector_next = group_any_result & group_enable_reg;

    // Group enables: ones in the set word enable, ones in the clear word disable; zeros do nothing.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            group_enable_reg <= GROUP_ENABLE_RESET;
        end else if (wr_set) begin
            group_enable_reg <= group_enable_reg
                | (wb_req_i.dat[GROUP_MSB:GROUP_LSB] & lane_mask(wb_req_i.sel));
        end else if (wr_clear) begin
            group_enable_reg <= group_enable_reg
                & ~(wb_req_i.dat[GROUP_MSB:GROUP_LSB] & lane_mask(wb_req_i.sel));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            group_vector_reg <= GROUP_VECTOR_RESET;
        end else begin
            group_vector_reg <= group_vector_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= UNMAPPED_READ_VALUE;
        end else begin
            ack_reg <= access;
            if (access && !wb_req_i.we) begin
                if (wb_req_i.adr == GROUP_ENABLE_SET_OFFSET) begin
                    rdata_reg <= place_groups(group_enable_reg);
                end else if (wb_req_i.adr == GROUP_ENABLE_CLEAR_OFFSET) begin
                    rdata_reg <= place_groups(group_enable_reg);
                end else if (wb_req_i.adr == GROUP_INTERRUPT_VECTOR_OFFSET) begin
                    rdata_reg <= place_groups(group_vector_reg);
                end else begin
                    rdata_reg <= UNMAPPED_READ_VALUE;
                end
            end
        end
    end

    assign wb_ans_o.ack = ack_reg;
    assign wb_ans_o.dat = rdata_reg;
    assign group_irq_o = group_vector_reg;

    a_clear_disables: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clear && !wr_set |=> ((group_enable_reg & $past(wb_req_i.dat[GROUP_MSB:GROUP_LSB]
            & lane_mask(wb_req_i.sel))) == '0))
        else $error("clear write left a group enabled");
    a_set_enables: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_set |=> ((group_enable_reg & $past(wb_req_i.dat[GROUP_MSB:GROUP_LSB] & lane_mask(wb_req_i.sel)))
            == $past(wb_req_i.dat[GROUP_MSB:GROUP_LSB] & lane_mask(wb_req_i.sel))))
        else $error("set write left a group disabled");
    a_enable_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_set && !wr_clear |=> $stable(group_enable_reg))
        else $error("group enable changed without a write");
    a_clear_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_req_i.we && wb_req_i.adr == GROUP_ENABLE_CLEAR_OFFSET
            |=> wb_ans_o.ack && wb_ans_o.dat[GROUP_MSB:GROUP_LSB] == $past(group_enable_reg)
            && wb_ans_o.dat[31:27] == 5'h00 && wb_ans_o.dat[7:0] == 8'h00)
        else $error("clear register read did not show the enables");
    a_vector_track: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> group_irq_o == ($past(group_any_result) & $past(group_enable_reg)))
        else $error("vector does not follow gated results");
    a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (group_irq_o & ~$past(group_enable_reg)) == '0)
        else $error("disabled group raised its interrupt");
    a_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> group_enable_reg == '0 && group_irq_o == '0 && !wb_ans_o.ack)
        else $error("state not zero after reset");
    a_result_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (group_any_result[0] == |(source_flag_bit_i[SOURCE_COUNT-1:0]
            & source_enable_bit_i[SOURCE_COUNT-1:0])))
        else $error("result of group zero wrong");
    a_vector_or: assert property (@(posedge clk_i) disable iff (rst_i)
        group_enable_reg[0] && group_any_result[0] |=> group_irq_o[0])
        else $error("enabled group with result not raised");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ans_o.ack |=> !wb_ans_o.ack)
        else $error("ack held longer than one cycle");

    // Reading the set word shows the same live enables as the clear word.
    a_set_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_set
            |=> wb_ans_o.ack && wb_ans_o.dat[GROUP_MSB:GROUP_LSB] == $past(group_enable_reg))
        else $error("set register read did not show the enables");

    // Reading the vector word shows the lines as they stood when the read was taken.
    a_vector_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_vector
            |=> wb_ans_o.ack && wb_ans_o.dat[GROUP_MSB:GROUP_LSB] == $past(group_irq_o))
        else $error("vector register read did not show the lines");

    // Addresses outside the map read as zero.
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_other
            |=> wb_ans_o.ack && wb_ans_o.dat == UNMAPPED_READ_VALUE)
        else $error("unmapped read returned data");

    // Reserved bits of every word read as zero, whatever was read last.
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ans_o.ack
            |-> wb_ans_o.dat[31:27] == 5'h00 && wb_ans_o.dat[7:0] == 8'h00)
        else $error("reserved read bits not zero");

    // Every taken request is answered in the next cycle.
    a_ack_after_access: assert property (@(posedge clk_i) disable iff (rst_i)
        access
            |=> wb_ans_o.ack)
        else $error("request not acknowledged");

    // No answer appears without a request taken one cycle before.
    a_ack_needs_access: assert property (@(posedge clk_i) disable iff (rst_i)
        !access
            |=> !wb_ans_o.ack)
        else $error("acknowledge without request");

    // A write to the read-only vector word must not touch the enables.
    a_vector_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_vector
            |=> $stable(group_enable_reg))
        else $error("vector write changed the enables");

    // A clear write of all zeros changes nothing.
    a_clear_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clear && wr_bits == '0
            |=> $stable(group_enable_reg))
        else $error("zero clear write changed the enables");

    // A set write of all zeros changes nothing.
    a_set_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_set && wr_bits == '0
            |=> $stable(group_enable_reg))
        else $error("zero set write changed the enables");

    // A clear write can only lower enables, never raise one.
    a_clear_only_lowers: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clear
            |=> (group_enable_reg & ~$past(group_enable_reg)) == '0)
        else $error("clear write raised an enable");

    // A set write can only raise enables, never lower one.
    a_set_only_raises: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_set
            |=> ($past(group_enable_reg) & ~group_enable_reg) == '0)
        else $error("set write lowered an enable");

    // A clear write lowers exactly the ones it carries and keeps every other group.
    a_clear_exact: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clear
            |=> group_enable_reg == ($past(group_enable_reg) & ~$past(wr_bits)))
        else $error("clear write touched the wrong groups");

    // A set write raises exactly the ones it carries and keeps every other group.
    a_set_exact: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_set
            |=> group_enable_reg == ($past(group_enable_reg) | $past(wr_bits)))
        else $error("set write touched the wrong groups");

    // Groups zero to seven sit in byte lane one; without that lane they are left alone.
    a_lane_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clear && !wb_req_i.sel[1]
            |=> group_enable_reg[7:0] == $past(group_enable_reg[7:0]))
        else $error("clear write without lane one touched low groups");

    // A line can only be high if its group was enabled in the cycle before.
    a_line_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        group_irq_o != '0
            |-> (group_irq_o & ~$past(group_enable_reg)) == '0)
        else $error("line high for a group that was disabled");

    // A line can only be high if its group had a result in the cycle before.
    a_line_needs_result: assert property (@(posedge clk_i) disable iff (rst_i)
        group_irq_o != '0
            |-> (group_irq_o & ~$past(group_any_result)) == '0)
        else $error("line high for a group without a result");

    // Per-group checks, so that a fault in one group's gating is named by its index.
    genvar ci;
    generate
        for (ci = 0; ci < GROUP_COUNT; ci++) begin : g_group_check
            // A disabled group keeps its line low in the next cycle.
            a_group_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
                !group_enable_reg[ci]
                    |=> !group_irq_o[ci])
                else $error("disabled group drove its line");

            // An enabled group without a result keeps its line low.
            a_group_or: assert property (@(posedge clk_i) disable iff (rst_i)
                group_enable_reg[ci] && !group_any_result[ci]
                    |=> !group_irq_o[ci])
                else $error("group line high without a result");

            // An enabled group with a result raises its line.
            a_group_raise: assert property (@(posedge clk_i) disable iff (rst_i)
                group_enable_reg[ci] && group_any_result[ci]
                    |=> group_irq_o[ci])
                else $error("enabled group with a result stayed low");

            // The group result is set only by a source whose flag and enable are both one.
            a_group_source: assert property (@(posedge clk_i) disable iff (rst_i)
                group_any_result[ci]
                    |-> (source_flag_bit_i[ci*SOURCE_COUNT +: SOURCE_COUNT]
                        & source_enable_bit_i[ci*SOURCE_COUNT +: SOURCE_COUNT]) != '0)
                else $error("group result without a qualified source");
        end
    endgenerate

    c_lane_partial: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_clear && wb_req_i.sel != 4'hF);
    c_set_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_set);
    c_clear_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_clear);
    c_irq_raised: cover property (@(posedge clk_i) disable iff (rst_i) $rose(group_irq_o[0]));
    c_vector_read: cover property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_req_i.we && wb_req_i.adr == GROUP_INTERRUPT_VECTOR_OFFSET);
endmodule : interrupt_group_block_enable

// File: testbench/core_irq_model.sv
// Model of the core interrupt controller that samples the group lines.
module core_irq_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Group lines in, sampled lines out.
    input wire logic [group_irq_pkg::GROUP_COUNT-1:0] group_irq_i,
    output logic [group_irq_pkg::GROUP_COUNT-1:0] line_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import group_irq_pkg::*;
    always_ff @(posedge clk_i) begin
        line_seen_o <= rst_i ? '0 : group_irq_i;
    end
endmodule : core_irq_model

// File: testbench/interrupt_group_block_enable_tb.sv
// Testbench of the group block enable logic.
module interrupt_group_block_enable_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import group_irq_pkg::*;
    localparam int W = GROUP_COUNT * SOURCE_COUNT;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_request_type wb_req = '0;
    wb_answer_type wb_ans;
    logic [W-1:0] flag = '0;
    logic [W-1:0] en = '0;
    logic [GROUP_COUNT-1:0] irq;
    logic [GROUP_COUNT-1:0] seen_irq;
    logic [GROUP_COUNT-1:0] ge = '0;
    logic [GROUP_COUNT-1:0] act = '0;
    logic [31:0] q;
    logic [3:0] wsel = 4'hF;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #10 clk_i = ~clk_i;
    interrupt_group_block_enable i_interrupt_group_block_enable (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wb_req), .wb_ans_o(wb_ans), .source_flag_bit_i(flag), .source_enable_bit_i(en),
        .group_irq_o(irq));
    core_irq_model i_core_irq_model (.clk_i(clk_i), .rst_i(rst_i), .group_irq_i(irq), .line_seen_o(seen_irq));
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic access(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: wsel, adr: adr, dat: dat};
        do @(posedge clk_i); while (wb_ans.ack !== 1'b1);
        q = wb_ans.dat;
        wb_req <= '0;
    endtask : access
    task automatic expect_state();
        access(1'b0, 12'h204, 32'h0);
        check(q, {5'h00, ge, 8'h00});
        access(1'b0, 12'h200, 32'h0);
        check(q, {5'h00, ge, 8'h00});
        access(1'b0, 12'h208, 32'h0);
        check(q, {5'h00, ge & act, 8'h00});
        repeat (3) @(posedge clk_i);
        check({5'h00, seen_irq, 8'h00}, {5'h00, ge & act, 8'h00});
    endtask : expect_state
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        expect_state();
        flag <= '1;
        en <= '1;
        act = '1;
        expect_state();
        access(1'b1, 12'h200, 32'h07FFFF00);
        ge = 19'h7FFFF;
        expect_state();
        access(1'b1, 12'h204, 32'h00000500);
        ge = 19'h7FFFA;
        expect_state();
        access(1'b1, 12'h200, 32'h0);
        access(1'b1, 12'h204, 32'h0);
        access(1'b1, 12'h208, 32'hFFFFFFFF);
        expect_state();
        flag <= ~(W'(31'h7FFFFFFF) << 31);
        en <= ~(W'(31'h7FFFFFFF) << 93);
        act = 19'h7FFF5;
        expect_state();
        access(1'b0, 12'h300, 32'h0);
        check(q, 32'h00000000);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        ge = '0;
        expect_state();
        access(1'b1, 12'h200, 32'h07FFFF00);
        wsel <= 4'h2;
        access(1'b1, 12'h204, 32'hFFFFFFFF);
        wsel <= 4'hF;
        ge = 19'h7FF00;
        expect_state();
        tally_and_finish();
    end
endmodule : interrupt_group_block_enable_tb
